/* rtl/atc_timer.sv */
// Advanced timer: capture, compare, complementary PWM with dead-time, Wishbone slave
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module atc_timer #(
  parameter int NCH = 3,
  parameter int CW  = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [31:0]       dat_i,
  input  wire logic [3:0]        sel_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  input  wire logic              dbgHalt,
  input  wire logic [2*NCH-1:0]  chanIn,
  output logic      [2*NCH-1:0]  chanOut,
  output logic      [2*NCH-1:0]  chanOe,
  output logic      [2*NCH-1:0]  dmaReq,
  output logic                   irqReq
);
  localparam int NH = 2 * NCH;

  // A fourth channel control word would land on the dead-time register
  if (NCH < 1 || NCH > 3 || CW < 8 || CW > 32) begin : gChk
    $error("atc_timer: NCH must be 1..3 and CW 8..32");
  end

  // Architectural registers
  logic [CW-1:0] arr_r, arr_nxt, cnt_r, cnt_nxt;
  logic [31:0]   cr_r, cr_nxt, dtr_r, dtr_nxt, dbg_r, dbg_nxt;
  logic [31:0]   chcr_r [NCH];
  logic [31:0]   chcr_nxt [NCH];
  logic [CW-1:0] ccr_r [NH];
  logic [CW-1:0] ccr_nxt [NH];
  logic [NH:0]   isr_r, isr_nxt;
  logic          down_r, down_nxt;
  logic [31:0]   datO_nxt;
  logic          ack_nxt, irq_nxt;
  // Per-half events and interrupt enables from the channel logic
  logic [NH-1:0] capEv, cmpEv, halfIe;

  logic          busWr, busRd, cntRun, edgeMode, centerMode, timerEn, updEv;
  logic [31:0]   wrMask;

  assign busWr      = cyc_i & stb_i & we_i & ~ack_o;
  assign busRd      = cyc_i & stb_i & ~we_i & ~ack_o;
  assign wrMask     = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign timerEn    = cr_r[atc_pkg::CR_EN];
  assign edgeMode   = cr_r[atc_pkg::CR_MODE_LO +: 2] == atc_pkg::MODE_EDGE;
  assign centerMode = cr_r[atc_pkg::CR_MODE_LO +: 2] == atc_pkg::MODE_CENTER;
  // Freeze only when the debug bit asks for it; otherwise debug has no effect
  assign cntRun     = timerEn & ~(dbg_r[atc_pkg::DBG_FREEZE] & dbgHalt);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // Counter, control registers and bus answers
  always_comb begin
    logic [31:0] cntW;
    cntW     = merge({{(32-CW){1'b0}}, cnt_r}, dat_i, wrMask);
    arr_nxt  = arr_r;
    cnt_nxt  = cnt_r;
    down_nxt = down_r;
    cr_nxt   = cr_r;
    dtr_nxt  = dtr_r;
    dbg_nxt  = dbg_r;
    updEv    = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      chcr_nxt[c] = chcr_r[c];
    end
    if (cntRun) begin
      if (centerMode) begin
        if (!down_r && cnt_r >= arr_r) begin
          down_nxt = 1'b1;
          cnt_nxt  = cnt_r - 1'b1;
        end else if (down_r && cnt_r == '0) begin
          down_nxt = 1'b0;
          cnt_nxt  = cnt_r + 1'b1;
          updEv    = 1'b1;
        end else begin
          cnt_nxt  = down_r ? cnt_r - 1'b1 : cnt_r + 1'b1;
        end
      end else begin
        down_nxt = 1'b0;
        if (cnt_r >= arr_r) begin
          cnt_nxt = '0;
          updEv   = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
    end
    if (busWr) begin
      unique case (adr_i)
        atc_pkg::OFF_ARR: arr_nxt = CW'(merge({{(32-CW){1'b0}}, arr_r}, dat_i, wrMask));
        atc_pkg::OFF_CNT: cnt_nxt = CW'(cntW);
        atc_pkg::OFF_CR:  cr_nxt  = merge(cr_r, dat_i, wrMask);
        atc_pkg::OFF_DTR: dtr_nxt = merge(dtr_r, dat_i, wrMask);
        atc_pkg::OFF_DBG: dbg_nxt = merge(dbg_r, dat_i, wrMask);
        default: begin
          for (int c = 0; c < NCH; c++) begin
            if (adr_i == 8'(atc_pkg::OFF_CHCR + 4 * c)) begin
              chcr_nxt[c] = merge(chcr_r[c], dat_i, wrMask);
            end
          end
        end
      endcase
    end
    // Sticky flags: clear by writing 0, a same-cycle event still sets
    isr_nxt = isr_r;
    if (busWr && adr_i == atc_pkg::OFF_ICR) begin
      isr_nxt = isr_r & (dat_i[NH:0] | ~wrMask[NH:0]);
    end
    isr_nxt = isr_nxt | {updEv, capEv | cmpEv};
    for (int h = 0; h < NH; h++) begin
      ccr_nxt[h] = ccr_r[h];
      if (busWr && adr_i == 8'(atc_pkg::OFF_CCR + 4 * h)) begin
        ccr_nxt[h] = CW'(merge({{(32-CW){1'b0}}, ccr_r[h]}, dat_i, wrMask));
      end
      if (capEv[h]) begin
        ccr_nxt[h] = cnt_r;
      end
    end
    datO_nxt = 32'h0000_0000;
    if (busRd) begin
      unique case (adr_i)
        atc_pkg::OFF_ARR: datO_nxt = {{(32-CW){1'b0}}, arr_r};
        atc_pkg::OFF_CNT: datO_nxt = {{(32-CW){1'b0}}, cnt_r};
        atc_pkg::OFF_CR:  datO_nxt = cr_r;
        atc_pkg::OFF_ISR: datO_nxt = {{(31-NH){1'b0}}, isr_r};
        atc_pkg::OFF_DTR: datO_nxt = dtr_r;
        atc_pkg::OFF_DBG: datO_nxt = dbg_r;
        default: begin
          for (int c = 0; c < NCH; c++) begin
            if (adr_i == 8'(atc_pkg::OFF_CHCR + 4 * c)) datO_nxt = chcr_r[c];
          end
          for (int h = 0; h < NH; h++) begin
            if (adr_i == 8'(atc_pkg::OFF_CCR + 4 * h)) datO_nxt = {{(32-CW){1'b0}}, ccr_r[h]};
          end
        end
      endcase
    end
    // Unmapped addresses still answer, reads return zero
    ack_nxt = cyc_i & stb_i & ~ack_o;
    irq_nxt = |(isr_r[NH-1:0] & halfIe);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      arr_r  <= CW'(atc_pkg::ARR_RESET);
      cnt_r  <= '0;
      down_r <= 1'b0;
      cr_r   <= atc_pkg::CR_RESET;
      dtr_r  <= 32'h0000_0000;
      dbg_r  <= 32'h0000_0000;
      isr_r  <= '0;
      dat_o  <= 32'h0000_0000;
      ack_o  <= 1'b0;
      irqReq <= 1'b0;
      for (int c = 0; c < NCH; c++) chcr_r[c] <= 32'h0000_0000;
      for (int h = 0; h < NH; h++) ccr_r[h] <= '0;
    end else begin
      arr_r  <= arr_nxt;
      cnt_r  <= cnt_nxt;
      down_r <= down_nxt;
      cr_r   <= cr_nxt;
      dtr_r  <= dtr_nxt;
      dbg_r  <= dbg_nxt;
      isr_r  <= isr_nxt;
      dat_o  <= datO_nxt;
      ack_o  <= ack_nxt;
      irqReq <= irq_nxt;
      for (int c = 0; c < NCH; c++) chcr_r[c] <= chcr_nxt[c];
      for (int h = 0; h < NH; h++) ccr_r[h] <= ccr_nxt[h];
    end
  end

  // Per-half input filter, capture, compare reference
  logic [NH-1:0] ref_r;
  logic [NH-1:0] halfPol;
  logic [NH-1:0] halfFsel;

  for (genvar h = 0; h < NH; h++) begin : gHalf
    logic [15:0] cfg;
    logic [2:0]  ocm;
    logic [7:0]  fcnt_r, fcnt_nxt, fthr;
    logic        filt_r, filt_nxt, prev_r, prev_nxt, dma_nxt, ref_nxt;
    logic        actEdge, anyEdge, lt;
    logic [CW-1:0] cmpVal;

    assign cfg         = chcr_r[h / 2][(h % 2) * atc_pkg::HALF_SHIFT +: 16];
    assign ocm         = cfg[atc_pkg::HF_OCM_LO +: 3];
    assign halfIe[h]   = cfg[atc_pkg::HF_IE];
    assign halfPol[h]  = cfg[atc_pkg::HF_POL];
    assign halfFsel[h] = cfg[atc_pkg::HF_FSEL];
    assign fthr        = 8'h01 << cfg[atc_pkg::HF_FLT_LO +: 3];
    // Polarity 1 turns the rising-edge selection into falling
    assign actEdge = (filt_r ^ halfPol[h]) & ~(prev_r ^ halfPol[h]);
    assign anyEdge = filt_r ^ prev_r;
    // Capture only in edge-aligned mode with the timer enabled
    assign capEv[h] = halfFsel[h] & timerEn & edgeMode &
                      ((cfg[atc_pkg::HF_EDGE_LO +: 2] == atc_pkg::EDGE_RISE & actEdge) |
                       (cfg[atc_pkg::HF_EDGE_LO +: 2] == atc_pkg::EDGE_BOTH & anyEdge));
    assign cmpEv[h] = ~halfFsel[h] & cntRun & (cnt_r == ccr_r[h]);
    // Half A in two-point center mode uses B's value while counting down
    assign cmpVal = (h % 2 == 0 && centerMode && !cr_r[atc_pkg::CR_PTSEL] && down_r) ?
                    ccr_r[h + 1 - (h % 2)] : ccr_r[h];
    assign lt = cnt_r < cmpVal;

    always_comb begin
      // A new level must hold for fthr clocks before it is accepted
      filt_nxt = filt_r;
      fcnt_nxt = 8'h00;
      if (chanIn[h] != filt_r) begin
        if (fcnt_r + 8'h01 >= fthr) begin
          filt_nxt = chanIn[h];
        end else begin
          fcnt_nxt = fcnt_r + 8'h01;
        end
      end
      prev_nxt = filt_r;
      dma_nxt  = capEv[h] & cfg[atc_pkg::HF_DE];
      ref_nxt  = ref_r[h];
      if (!halfFsel[h]) begin
        unique case (ocm)
          atc_pkg::OCM_TOGGLE: ref_nxt = cmpEv[h] ? ~ref_r[h] : ref_r[h];
          atc_pkg::OCM_PWM1:   ref_nxt = lt;
          atc_pkg::OCM_PWM2:   ref_nxt = ~lt;
          default:             ref_nxt = ref_r[h];
        endcase
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        filt_r    <= 1'b0;
        fcnt_r    <= 8'h00;
        prev_r    <= 1'b0;
        dmaReq[h] <= 1'b0;
        ref_r[h]  <= 1'b0;
      end else begin
        filt_r    <= filt_nxt;
        fcnt_r    <= fcnt_nxt;
        prev_r    <= prev_nxt;
        dmaReq[h] <= dma_nxt;
        ref_r[h]  <= ref_nxt;
      end
    end

    AST_CAP_VALUE: assert property (@(posedge clk_sys) disable iff (!reset_n)
      capEv[h] |=> ccr_r[h] == $past(cnt_r)) else $error("capture value wrong");
    AST_CAP_GATED: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !(timerEn && edgeMode && halfFsel[h]) &&
      !(busWr && adr_i == 8'(atc_pkg::OFF_CCR + 4 * h)) |=> $stable(ccr_r[h]))
      else $error("capture not allowed");
    AST_DMA_PULSE: assert property (@(posedge clk_sys) disable iff (!reset_n)
      capEv[h] && cfg[atc_pkg::HF_DE] |=> dmaReq[h] ##1 (!dmaReq[h] || $past(capEv[h])))
      else $error("dma request missing");
    AST_TOGGLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !halfFsel[h] && ocm == atc_pkg::OCM_TOGGLE && cmpEv[h] |=> ref_r[h] != $past(ref_r[h]))
      else $error("toggle missed");
  end

  // Per-channel output stage: complementary pair, dead-time, main enable
  for (genvar c = 0; c < NCH; c++) begin : gOut
    logic [atc_pkg::DT_LEN_W-1:0] dt_r, dt_nxt;
    logic                         refPrev_r, outA_nxt, outB_nxt, oeA_nxt, oeB_nxt;
    logic                         comp, mainOe, rawA, rawB;

    assign comp   = cr_r[atc_pkg::CR_COMP];
    assign mainOe = dtr_r[atc_pkg::DT_OEN];
    assign rawA = ref_r[2 * c];
    assign rawB = comp ? ~ref_r[2 * c] : ref_r[2 * c + 1];

    always_comb begin
      dt_nxt = (dt_r != '0) ? dt_r - 1'b1 : dt_r;
      if (comp && dtr_r[atc_pkg::DT_EN] && rawA != refPrev_r) begin
        dt_nxt = dtr_r[atc_pkg::DT_LEN_LO +: atc_pkg::DT_LEN_W];
      end
      // During the dead band both switches sit at their inactive level
      outA_nxt = ((dt_nxt != '0) ? 1'b0 : rawA) ^ halfPol[2 * c];
      outB_nxt = ((dt_nxt != '0) ? 1'b0 : rawB) ^ halfPol[2 * c + 1];
      oeA_nxt  = mainOe & ~halfFsel[2 * c];
      oeB_nxt  = mainOe & ~halfFsel[2 * c + 1];
      if (!mainOe) begin
        outA_nxt = 1'b0;
        outB_nxt = 1'b0;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        dt_r           <= '0;
        refPrev_r      <= 1'b0;
        chanOut[2*c]   <= 1'b0;
        chanOut[2*c+1] <= 1'b0;
        chanOe[2*c]    <= 1'b0;
        chanOe[2*c+1]  <= 1'b0;
      end else begin
        dt_r           <= dt_nxt;
        refPrev_r      <= rawA;
        chanOut[2*c]   <= outA_nxt;
        chanOut[2*c+1] <= outB_nxt;
        chanOe[2*c]    <= oeA_nxt;
        chanOe[2*c+1]  <= oeB_nxt;
      end
    end

    AST_DEADBAND: assert property (@(posedge clk_sys) disable iff (!reset_n)
      dt_r != '0 && mainOe && $past(mainOe) |-> chanOut[2*c] == halfPol[2*c] ||
      $past(halfPol[2*c]) != halfPol[2*c]) else $error("output active in dead band");
    AST_OUT_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !mainOe |=> !chanOe[2*c] && !chanOe[2*c+1] && !chanOut[2*c] && !chanOut[2*c+1])
      else $error("output while disabled");
  end

  // Checks on counter, flags and bus
  logic cntWrite, icrWrite;
  assign cntWrite = busWr && adr_i == atc_pkg::OFF_CNT;
  assign icrWrite = busWr && adr_i == atc_pkg::OFF_ICR;

  AST_FREEZE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    dbg_r[atc_pkg::DBG_FREEZE] && dbgHalt && !cntWrite |=> $stable(cnt_r))
    else $error("counter moved while frozen");
  AST_RUN_IN_DEBUG: assert property (@(posedge clk_sys) disable iff (!reset_n)
    timerEn && !dbg_r[atc_pkg::DBG_FREEZE] && edgeMode && cnt_r < arr_r && !cntWrite
    |=> cnt_r == $past(cnt_r) + 1'b1) else $error("counter did not advance");
  AST_FLAG_STICKY: assert property (@(posedge clk_sys) disable iff (!reset_n)
    isr_r[0] && !icrWrite |=> isr_r[0]) else $error("flag dropped without clear");
  AST_FLAG_CLEAR: assert property (@(posedge clk_sys) disable iff (!reset_n)
    icrWrite && sel_i[0] && !dat_i[0] && !capEv[0] && !cmpEv[0] |=> !isr_r[0])
    else $error("flag not cleared");
  AST_IRQ: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (isr_r[NH-1:0] & halfIe) != '0 |=> irqReq) else $error("interrupt missing");
  AST_ACK_ONE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("ack timing wrong");

  COV_CAPTURE: cover property (@(posedge clk_sys) disable iff (!reset_n) capEv[0]);
  COV_DEADBAND: cover property (@(posedge clk_sys) disable iff (!reset_n) gOut[0].dt_r != '0);
  COV_CENTER_TURN: cover property (@(posedge clk_sys) disable iff (!reset_n)
    centerMode && !down_r ##1 down_r);
  COV_FREEZE: cover property (@(posedge clk_sys) disable iff (!reset_n)
    timerEn && dbgHalt && dbg_r[atc_pkg::DBG_FREEZE]);
endmodule
`default_nettype wire

/* pkg/atc_pkg.sv */
// Constants for the advanced timer capture/compare/PWM block
package atc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_ARR   = 8'h00;
  localparam logic [7:0] OFF_CNT   = 8'h04;
  localparam logic [7:0] OFF_CR    = 8'h0C;
  localparam logic [7:0] OFF_ISR   = 8'h10;
  localparam logic [7:0] OFF_ICR   = 8'h14;
  localparam logic [7:0] OFF_CHCR  = 8'h24;  // Channel n control at OFF_CHCR + 4*n
  localparam logic [7:0] OFF_DTR   = 8'h30;
  localparam logic [7:0] OFF_CCR   = 8'h3C;  // Half h capture/compare at OFF_CCR + 4*h
  localparam logic [7:0] OFF_DBG   = 8'h60;
  // Control register fields
  localparam int CR_EN      = 0;
  localparam int CR_MODE_LO = 1;
  localparam int CR_COMP    = 3;
  localparam int CR_PTSEL   = 4;
  localparam logic [1:0] MODE_EDGE   = 2'h2;
  localparam logic [1:0] MODE_CENTER = 2'h3;
  // Per-half fields inside a channel control register, half B at +HALF_SHIFT
  localparam int HALF_SHIFT = 16;
  localparam int HF_FSEL    = 0;
  localparam int HF_EDGE_LO = 1;
  localparam int HF_IE      = 3;
  localparam int HF_DE      = 4;
  localparam int HF_POL     = 5;
  localparam int HF_OCM_LO  = 6;
  localparam int HF_FLT_LO  = 9;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [2:0] OCM_TOGGLE = 3'h4;
  localparam logic [2:0] OCM_PWM1   = 3'h6;
  localparam logic [2:0] OCM_PWM2   = 3'h7;
  // Dead-time register fields
  localparam int DT_LEN_LO = 0;
  localparam int DT_LEN_W  = 8;
  localparam int DT_EN     = 8;
  localparam int DT_OEN    = 9;
  // Debug control and status, register reset values
  localparam int DBG_FREEZE = 0;
  localparam int ISR_UPD    = 8;
  localparam logic [31:0] CR_RESET = 32'h0000_0004;
  localparam logic [31:0] ARR_RESET = 32'h0000_FFFF;
endpackage

/* verif/atc_pin_model.sv */
// Far-side pin model: drives the capture inputs and measures the output pins
`timescale 1ns/1ps
`default_nettype none
module atc_pin_model #(
  parameter int NH = 6
) (
  input  wire logic          clk_sys,
  input  wire logic [NH-1:0] chanOut,
  input  wire logic [NH-1:0] chanOe,
  output var  logic [NH-1:0] chanIn
);
  logic [NH-1:0] pin;
  // A released pin reads low, as through the board pull-down
  assign pin = chanOut & chanOe;
  initial chanIn = '0;
  // Each level is held for hold clocks, so back-to-back drives put edges hold plus one clocks apart
  task automatic drive(input int h, input logic lvl, input int hold);
    @(posedge clk_sys);
    chanIn[h] <= lvl;
    repeat (hold) @(posedge clk_sys);
  endtask
  // Dead bands cut by the window ends would spoil the count, so skip and finish them
  task automatic watch(input int h, input int n, output int hi, output int tog,
                       output int lowBoth, output int both, output int bands);
    logic p;
    logic inBand;
    hi = 0;
    tog = 0;
    lowBoth = 0;
    both = 0;
    bands = 0;
    for (int i = 0; i < 64 && (pin[h] | pin[h+1]) === 1'b0; i++) @(posedge clk_sys);
    p = pin[h];
    inBand = 1'b0;
    for (int i = 0; i < n + 64 && (i < n || inBand); i++) begin
      @(posedge clk_sys);
      if (i < n && pin[h] === 1'b1) hi++;
      if (i < n && pin[h] !== p) tog++;
      p = pin[h];
      if ((pin[h] | pin[h+1]) === 1'b0) begin
        lowBoth++;
        if (!inBand) bands++;
      end
      if ((pin[h] & pin[h+1]) === 1'b1) both++;
      inBand = ((pin[h] | pin[h+1]) === 1'b0);
    end
  endtask
endmodule
`default_nettype wire

/* verif/tb_adv_timer_capture_pwm.sv */
// Self-checking bench for the timer capture, compare and PWM block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_adv_timer_capture_pwm;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wdat    = 32'h0000_0000;
  logic [3:0]  sel     = 4'hF;
  logic        dbgHalt = 1'b0;
  logic [31:0] rdat;
  logic        ack;
  logic [5:0]  chanIn;
  logic [5:0]  chanOut;
  logic [5:0]  chanOe;
  logic [5:0]  dmaReq;
  logic        irqReq;
  logic [31:0] q;
  logic [31:0] prev;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          hi, tog, lowBoth, both, bands;
  logic [2:0]  ocm [4] = '{atc_pkg::OCM_TOGGLE, atc_pkg::OCM_PWM1, atc_pkg::OCM_PWM2,
                           atc_pkg::OCM_PWM1};
  logic        pol [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  int          expHi [4] = '{0, 32, 96, 96};

  always #25 clk_sys = ~clk_sys;

  atc_timer #(.NCH(3), .CW(16)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack),
    .dbgHalt(dbgHalt), .chanIn(chanIn), .chanOut(chanOut), .chanOe(chanOe),
    .dmaReq(dmaReq), .irqReq(irqReq)
  );

  atc_pin_model #(.NH(6)) pin (
    .clk_sys(clk_sys), .chanOut(chanOut), .chanOe(chanOe), .chanIn(chanIn)
  );

  task automatic close_out();
    $display("compares %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    bit got;
    got = 1'b0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clk_sys);
      got = (ack === 1'b1);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (!got) begin
      num_errors++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // Drives one input edge, then counts request pulses on that half
  task automatic edge_count(input int h, input logic lvl);
    pin.drive(h, lvl, 0);
    hi = 0;
    repeat (12) begin
      @(posedge clk_sys);
      if (dmaReq[h] === 1'b1) hi++;
    end
  endtask

  initial begin
    #5_000_000;
    num_errors++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(atc_pkg::OFF_ARR);
    `CHK(q, atc_pkg::ARR_RESET)
    rd(atc_pkg::OFF_CR);
    `CHK(q, atc_pkg::CR_RESET)
    wr(8'h80, 32'hFFFF_FFFF);
    rd(8'h80);
    `CHK(q, 32'h0000_0000)
    rd(atc_pkg::OFF_ICR);
    `CHK(q, 32'h0000_0000)
    done("reset");
    // DMA enabled in the channel before the timer runs
    wr(atc_pkg::OFF_CHCR, 32'h0000_001B);
    edge_count(0, 1'b1);
    `CHK(hi, 0)
    rd(atc_pkg::OFF_ISR);
    `CHK(q[5:0], 6'h00)
    pin.drive(0, 1'b0, 4);
    wr(atc_pkg::OFF_DBG, 32'h0000_0001);
    dbgHalt <= 1'b1;
    wr(atc_pkg::OFF_CNT, 32'h0000_0123);
    wr(atc_pkg::OFF_CR, 32'h0000_0005);
    rd(atc_pkg::OFF_CNT);
    `CHK(q, 32'h0000_0123)
    // Request line 0 is the channel 1A trigger source
    edge_count(0, 1'b1);
    `CHK(hi, 1)
    rd(atc_pkg::OFF_CCR);
    `CHK(q, 32'h0000_0123)
    repeat (20) @(posedge clk_sys);
    rd(atc_pkg::OFF_ISR);
    `CHK(q[0], 1'b1)
    `CHK(irqReq, 1'b1)
    wr(atc_pkg::OFF_ICR, 32'hFFFF_FFFE);
    rd(atc_pkg::OFF_ISR);
    `CHK(q[0], 1'b0)
    `CHK(irqReq, 1'b0)
    edge_count(0, 1'b0);
    `CHK(hi, 0)
    // Polarity set: the rising-edge selection now captures falling edges
    wr(atc_pkg::OFF_CHCR, 32'h0000_003B);
    edge_count(0, 1'b1);
    `CHK(hi, 0)
    edge_count(0, 1'b0);
    `CHK(hi, 1)
    done("capture 1A");
    wr(8'h2C, 32'h0407_0000);
    wr(atc_pkg::OFF_CNT, 32'h0000_0200);
    pin.drive(5, 1'b1, 1);
    pin.drive(5, 1'b0, 12);
    rd(atc_pkg::OFF_ISR);
    `CHK(q[5], 1'b0)
    pin.drive(5, 1'b1, 12);
    rd(8'h50);
    `CHK(q, 32'h0000_0200)
    wr(atc_pkg::OFF_CNT, 32'h0000_0300);
    pin.drive(5, 1'b0, 12);
    rd(8'h50);
    `CHK(q, 32'h0000_0300)
    rd(atc_pkg::OFF_ISR);
    `CHK(q[5], 1'b1)
    wr(atc_pkg::OFF_DBG, 32'h0000_0000);
    rd(atc_pkg::OFF_CNT);
    prev = q;
    rd(atc_pkg::OFF_CNT);
    `CHK(q === prev, 1'b0)
    dbgHalt <= 1'b0;
    done("capture 3B and debug");
    // Counter loaded below the reload value before outputs run
    wr(atc_pkg::OFF_ARR, 32'h0000_001F);
    wr(atc_pkg::OFF_CNT, 32'h0000_0000);
    wr(8'h44, 32'h0000_0008);
    wr(atc_pkg::OFF_DTR, 32'h0000_0200);
    for (int k = 0; k < 4; k++) begin
      wr(8'h28, {23'h0, ocm[k], pol[k], 5'h00});
      repeat (40) @(posedge clk_sys);
      pin.watch(2, 128, hi, tog, lowBoth, both, bands);
      if (k == 0) `CHK(tog, 4)
      else `CHK(hi, expHi[k])
    end
    wr(atc_pkg::OFF_DTR, 32'h0000_0000);
    repeat (4) @(posedge clk_sys);
    `CHK(chanOe, 6'h00)
    `CHK(chanOut, 6'h00)
    done("compare");
    wr(atc_pkg::OFF_CR, 32'h0000_0004);
    wr(atc_pkg::OFF_CNT, 32'h0000_0000);
    wr(atc_pkg::OFF_CCR, 32'h0000_0008);
    wr(8'h40, 32'h0000_0010);
    wr(atc_pkg::OFF_CHCR, 32'h0180_0180);
    wr(atc_pkg::OFF_DTR, 32'h0000_0200);
    wr(atc_pkg::OFF_CR, 32'h0000_000F);
    repeat (80) @(posedge clk_sys);
    pin.watch(0, 248, hi, tog, lowBoth, both, bands);
    `CHK(both, 0)
    `CHK(lowBoth, 0)
    // Four 62-clock periods, 7 high counting up below A plus 16 down below B
    `CHK(hi, 92)
    wr(atc_pkg::OFF_DTR, 32'h0000_0304);
    repeat (80) @(posedge clk_sys);
    pin.watch(0, 248, hi, tog, lowBoth, both, bands);
    `CHK(both, 0)
    `CHK(bands > 0, 1'b1)
    `CHK(lowBoth, 4 * bands)
    // Center-aligned counting refuses capture on the still configured 3B input
    pin.drive(5, 1'b1, 12);
    rd(8'h50);
    `CHK(q, 32'h0000_0300)
    done("complementary");
    close_out();
  end
endmodule
`default_nettype wire
